// file: iss_top.sv
// two-wire bus slave with clock stretching and an avalon-mm register port.
// assumes open-drain scl/sda resolved outside; clk far faster than scl.
`include "iss_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module iss_top (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [2:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	input  wire logic        sleeping,
	output logic             scl_out,
	output logic             scl_oe,
	output logic             sda_out,
	output logic             sda_oe
);

	iss_pkg::iss_state_t st;
	iss_pkg::iss_state_t after;
	logic       scl_m;
	logic       scl_s;
	logic       scl_d;
	logic       sda_m;
	logic       sda_s;
	logic       sda_d;
	logic [7:0] ctrl;
	logic [6:0] own_addr;
	logic [7:0] tx_data;
	logic       nack_act;
	logic [7:0] sh;
	logic [2:0] bitcnt;
	logic [3:0] cnt9;
	logic       any_bit;
	logic       in_frame;
	logic       addressed;
	logic       sda_want;
	logic       dir;
	logic       data_flag;
	logic       as_flag;
	logic       addr_kind;
	logic       coll;
	logic       bus_err;
	logic       recv_nack;
	logic [1:0] dly;
	logic [7:0] wake_cnt;
	logic [31:0] next_rdata;

	wire logic en        = ctrl[`ISS_CTRL_EN];
	wire logic scl_rise  = scl_s & ~scl_d;
	wire logic scl_fall  = ~scl_s & scl_d;
	wire logic start_det = scl_s & scl_d & sda_d & ~sda_s;
	wire logic stop_det  = scl_s & scl_d & ~sda_d & sda_s;
	wire logic wr        = avs_write & ~avs_waitrequest & avs_byteenable[0];
	wire logic [7:0] wd  = avs_writedata[7:0];
	wire logic cmd_valid = wr && avs_address == `ISS_REG_CMD
		&& wd[`ISS_CMD_GO] && (data_flag || as_flag);
	wire logic stat_w1c  = wr && avs_address == `ISS_REG_STAT;
	wire logic wake_busy = wake_cnt != 8'h00;
	// promiscuous accepts all; general call also matches
	wire logic match     = ctrl[`ISS_CTRL_PROM] || sh[6:0] == own_addr
		|| sh[6:0] == `ISS_GCALL;
	wire logic addr_last = st == iss_pkg::ISS_ADDR && scl_rise
		&& bitcnt == 3'h7;

	// pins cross into clk domain through two flops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_d <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_m <= scl_in;
			scl_s <= scl_m;
			scl_d <= scl_s;
			sda_m <= sda_in;
			sda_s <= sda_m;
			sda_d <= sda_s;
		end
	end

	// avalon slave: one wait cycle, then answer
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (avs_address)
			`ISS_REG_CTRL: next_rdata[7:0] = ctrl & 8'hbf;
			`ISS_REG_CMD:  next_rdata[`ISS_CMD_NACK] = nack_act;
			`ISS_REG_STAT: next_rdata[7:0] = {data_flag, as_flag, scl_oe,
				recv_nack, coll, bus_err, dir, addr_kind};
			`ISS_REG_OWN:  next_rdata[7:1] = own_addr;
			`ISS_REG_DATA: next_rdata[7:0] = sh;
			default:       next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= next_rdata;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl     <= `ISS_CTRL_RST;
			own_addr <= `ISS_OWN_RST;
			tx_data  <= 8'h00;
			nack_act <= 1'b0;
		end else if (wr) begin
			case (avs_address)
				`ISS_REG_CTRL: ctrl <= wd;
				`ISS_REG_CMD:  nack_act <= wd[`ISS_CMD_NACK];
				`ISS_REG_OWN:  own_addr <= wd[7:1];
				`ISS_REG_DATA: tx_data <= wd;
				default:       ctrl <= ctrl;
			endcase
		end
	end

	// bus protocol engine; hardware sets come after software clears
	// so an event in the clearing cycle is kept
	// collision check in ack and tx: sda low while released sets coll and drops to idle
	// no clock-low timeout, a stalled master locks the bus
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st        <= iss_pkg::ISS_IDLE;
			after     <= iss_pkg::ISS_IDLE;
			sh        <= 8'h00;
			bitcnt    <= 3'h0;
			cnt9      <= 4'h0;
			any_bit   <= 1'b0;
			in_frame  <= 1'b0;
			addressed <= 1'b0;
			sda_want  <= 1'b0;
			dir       <= 1'b0;
			data_flag <= 1'b0;
			as_flag   <= 1'b0;
			addr_kind <= 1'b0;
			coll      <= 1'b0;
			bus_err   <= 1'b0;
			recv_nack <= 1'b0;
		end else begin
			if (cmd_valid) begin
				data_flag <= 1'b0;
				as_flag   <= 1'b0;
			end
			if (stat_w1c) begin
				if (wd[`ISS_ST_DATA])
					data_flag <= 1'b0;
				if (wd[`ISS_ST_AS])
					as_flag <= 1'b0;
				if (wd[`ISS_ST_COLL])
					coll <= 1'b0;
				if (wd[`ISS_ST_BERR])
					bus_err <= 1'b0;
			end
			if (scl_rise && in_frame) begin
				// the rise ahead of a stop or sr is no bit: any_bit means
				// two rises, and a clean frame ends with cnt9 at one
				any_bit <= any_bit | (cnt9 != 4'h0);
				cnt9    <= (cnt9 == 4'h8) ? 4'h0 : cnt9 + 4'h1;
			end
			if (!en) begin
				st       <= iss_pkg::ISS_IDLE;
				sda_want <= 1'b0;
				in_frame <= 1'b0;
			end else if (start_det) begin
				if (in_frame && cnt9 != 4'h1)
					bus_err <= 1'b1;
				coll      <= 1'b0;
				in_frame  <= 1'b1;
				any_bit   <= 1'b0;
				cnt9      <= 4'h0;
				bitcnt    <= 3'h0;
				addressed <= 1'b0;
				sda_want  <= 1'b0;
				st        <= iss_pkg::ISS_ADDR;
			end else if (stop_det) begin
				if (in_frame && (!any_bit || cnt9 != 4'h1))
					bus_err <= 1'b1;
				if (addressed && ctrl[`ISS_CTRL_STOPIE]) begin
					as_flag   <= 1'b1;
					addr_kind <= 1'b0;
				end
				in_frame  <= 1'b0;
				addressed <= 1'b0;
				sda_want  <= 1'b0;
				st        <= iss_pkg::ISS_IDLE;
			end else begin
				unique case (st)
				iss_pkg::ISS_IDLE: begin
					sda_want <= 1'b0;
				end
				iss_pkg::ISS_ADDR: if (scl_rise) begin
					sh     <= {sh[6:0], sda_s};
					bitcnt <= bitcnt + 3'h1;
					if (bitcnt == 3'h7) begin
						if (match) begin
							as_flag   <= 1'b1;
							addr_kind <= 1'b1;
							dir       <= sda_s;
							addressed <= 1'b1;
							st        <= iss_pkg::ISS_HOLD;
						end else begin
							st <= iss_pkg::ISS_IDLE;
						end
					end
				end
				// address or received byte awaits a command
				iss_pkg::ISS_HOLD: if (cmd_valid) begin
					sda_want <= ~wd[`ISS_CMD_NACK]
						& (wd[`ISS_CMD_MORE] | ~dir);
					st <= iss_pkg::ISS_ACK;
					if (wd[`ISS_CMD_MORE] && !wd[`ISS_CMD_NACK])
						after <= dir ? iss_pkg::ISS_TXHOLD
							: iss_pkg::ISS_RX;
					else
						after <= iss_pkg::ISS_IDLE;
				end
				iss_pkg::ISS_ACK: begin
					// a nack pulled low by someone else is a collision too
					if (scl_rise && !sda_want && !sda_s) begin
						coll     <= 1'b1;
						sda_want <= 1'b0;
						st       <= iss_pkg::ISS_IDLE;
					end else if (scl_fall) begin
						sda_want <= 1'b0;
						bitcnt   <= 3'h0;
						st       <= after;
						if (after == iss_pkg::ISS_TXHOLD)
							data_flag <= 1'b1;
					end
				end
				iss_pkg::ISS_RX: if (scl_rise) begin
					sh     <= {sh[6:0], sda_s};
					bitcnt <= bitcnt + 3'h1;
					if (bitcnt == 3'h7) begin
						data_flag <= 1'b1;
						st        <= iss_pkg::ISS_HOLD;
					end
				end
				iss_pkg::ISS_TXHOLD: if (cmd_valid) begin
					if (wd[`ISS_CMD_MORE]) begin
						sh       <= tx_data;
						sda_want <= ~tx_data[7];
						bitcnt   <= 3'h0;
						st       <= iss_pkg::ISS_TX;
					end else begin
						st <= iss_pkg::ISS_IDLE;
					end
				end
				iss_pkg::ISS_TX: begin
					if (scl_rise && !sda_want && !sda_s) begin
						coll     <= 1'b1;
						sda_want <= 1'b0;
						st       <= iss_pkg::ISS_IDLE;
					end else if (scl_fall) begin
						bitcnt <= bitcnt + 3'h1;
						if (bitcnt == 3'h7) begin
							sda_want <= 1'b0;
							st       <= iss_pkg::ISS_TACK;
						end else begin
							sh       <= {sh[6:0], 1'b0};
							sda_want <= ~sh[6];
						end
					end
				end
				iss_pkg::ISS_TACK: begin
					if (scl_rise)
						recv_nack <= sda_s;
					if (scl_fall) begin
						if (recv_nack) begin
							st <= iss_pkg::ISS_IDLE;
						end else begin
							data_flag <= 1'b1;
							st        <= iss_pkg::ISS_TXHOLD;
						end
					end
				end
				endcase
			end
		end
	end

	// sda changes only after the hold delay following scl fall
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dly    <= 2'h0;
			sda_oe <= 1'b0;
		end else if (scl_fall) begin
			dly <= ctrl[`ISS_CTRL_HOLD] ? 2'(`ISS_HOLD_EXT_CYC)
				: 2'(`ISS_HOLD_BASE);
		end else if (dly != 2'h0) begin
			dly <= dly - 2'h1;
		end else begin
			sda_oe <= sda_want & en;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			wake_cnt <= 8'h00;
		else if (start_det && sleeping && en)
			wake_cnt <= 8'(`ISS_WAKE_CYC);
		else if (wake_busy)
			wake_cnt <= wake_cnt - 8'h01;
	end

	// joining only an already low scl avoids creating a glitch pulse
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			scl_oe  <= 1'b0;
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			scl_oe <= en && (data_flag || as_flag || wake_busy)
				&& (scl_oe || !scl_s);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_wake_start;
		start_det && sleeping && en;
	endsequence

	sequence s_matched;
		addr_last && match && !start_det && !stop_det && en;
	endsequence

	a_hold_after_low: assert property (
		$rose(scl_oe) |-> !$past(scl_s))
		else $error("scl hold started while scl high");
	a_wake_stretch: assert property (
		s_wake_start |=> wake_busy [*8])
		else $error("wake interval not held");
	a_flag_holds: assert property (
		en && (data_flag || as_flag) && !scl_s |=> scl_oe)
		else $error("pending flag without clock hold");
	a_match_flag: assert property (
		s_matched |=> as_flag && addr_kind && st == iss_pkg::ISS_HOLD)
		else $error("address match did not set flag");
	a_mismatch_idle: assert property (
		addr_last && !match && en && !stop_det |=> st == iss_pkg::ISS_IDLE)
		else $error("mismatch not ignored");
	a_dir_latch: assert property (
		s_matched |=> dir == $past(sda_s))
		else $error("direction not latched");
	a_cmd_clears: assert property (
		cmd_valid && !wake_busy && st != iss_pkg::ISS_ADDR && !stop_det
		|=> !data_flag && !as_flag ##1 !scl_oe)
		else $error("command did not release scl");
	a_start_coll: assert property (
		start_det && en |=> !coll)
		else $error("start did not clear collision");
	a_hold_extend: assert property (
		scl_fall && ctrl[`ISS_CTRL_HOLD] |=> $stable(sda_oe) [*3])
		else $error("sda changed before extended hold");
	a_stop_flag: assert property (
		stop_det && en && addressed && ctrl[`ISS_CTRL_STOPIE]
		|=> as_flag && !addr_kind)
		else $error("stop not flagged");
	a_start_stop: assert property (
		stop_det && en && in_frame && !any_bit |=> bus_err)
		else $error("start-stop not a bus error");

endmodule

`default_nettype wire

// file: iss_regs.svh
// register map, field positions, reset values and timing counts of the
// clock-stretching two-wire slave; included by the slave top and its test bench.
`ifndef ISS_REGS_SVH
`define ISS_REGS_SVH

// word indices on the avalon port
`define ISS_REG_CTRL     3'h0
`define ISS_REG_CMD      3'h1
`define ISS_REG_STAT     3'h2
`define ISS_REG_OWN      3'h3
`define ISS_REG_DATA     3'h4

// slave_control_a bits
`define ISS_CTRL_HOLD    7
`define ISS_CTRL_EN      3
`define ISS_CTRL_STOPIE  2
`define ISS_CTRL_PROM    1
`define ISS_CTRL_RST     8'h00

// slave_command register bits
`define ISS_CMD_NACK     2
`define ISS_CMD_GO       1
`define ISS_CMD_MORE     0

// status bits
`define ISS_ST_DATA      7
`define ISS_ST_AS        6
`define ISS_ST_COLL      3
`define ISS_ST_BERR      2

`define ISS_OWN_RST      7'h00
`define ISS_GCALL        7'h00

// timing
`define ISS_CLK_MHZ      40
`define ISS_HOLD_EXT_NS  50
`define ISS_HOLD_EXT_CYC ((`ISS_HOLD_EXT_NS * `ISS_CLK_MHZ + 999) / 1000)
`define ISS_HOLD_BASE    1
`define ISS_WAKE_NS      2000
`define ISS_WAKE_CYC     ((`ISS_WAKE_NS * `ISS_CLK_MHZ + 999) / 1000)

`endif

// file: iss_pkg.sv
// types of the clock-stretching two-wire slave.
// assumes the register header is included by its users.
package iss_pkg;
	typedef enum logic [2:0] {
		ISS_IDLE   = 3'b000,
		ISS_ADDR   = 3'b001,
		ISS_HOLD   = 3'b010,
		ISS_ACK    = 3'b011,
		ISS_RX     = 3'b100,
		ISS_TXHOLD = 3'b101,
		ISS_TX     = 3'b110,
		ISS_TACK   = 3'b111
	} iss_state_t;
endpackage

// file: iss_master_model.sv
// two-wire bus master model, driving scl and sda open-drain.
// assumes the bench resolves both wires with pull-ups.
`timescale 1ns/100ps
`default_nettype none
module iss_master_model (
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_low,
	output logic      sda_low
);
	logic lost;
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		lost = 1'b0;
	end
	// bounded: a stuck stretch must not hang the run
	task automatic wait_high();
		int n;
		n = 0;
		do begin
			#25;
			n++;
		end while (!scl && n < 40000);
	endtask
	// edges land 10 ns after a clock-aligned call, clear of the sampling edge
	task automatic start();
		#10;
		wait_high();
		#100 sda_low = 1'b1;
		#100 scl_low = 1'b1;
		#40;
	endtask
	task automatic rstart();
		#10 sda_low = 1'b0;
		#50 scl_low = 1'b0;
		#15;
		start();
	endtask
	task automatic stop();
		#10 sda_low = 1'b1;
		#50 scl_low = 1'b0;
		wait_high();
		#100 sda_low = 1'b0;
		#90;
	endtask
	// low period timed from our own fall, high only once scl is high;
	// 150 ns low and 50 ns high give a 200 ns bit
	task automatic bit_io(input logic b, output logic r);
		#10 sda_low = !b;
		#100 scl_low = 1'b0;
		wait_high();
		r = sda;
		#25 scl_low = 1'b1;
		#40;
	endtask
	task automatic wr8(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			if (d[i] && !r)
				lost = 1'b1;
		end
	endtask
	task automatic rd8(output logic [7:0] d);
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
	endtask
endmodule
`default_nettype wire

// file: iss_top_test.sv
// self-checking bench of the two-wire slave with a master model.
// assumes the register header and the slave top are compiled first.
`include "iss_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module iss_top_test;
	logic        clk, rstn, avs_read, avs_write, sleeping, r;
	logic [2:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd_v;
	logic        avs_waitrequest, scl_out, scl_oe, sda_out, sda_oe;
	logic        m_scl_low, m_sda_low, scl_w, sda_w;
	logic [7:0]  d;
	int          mismatches, total_checks, cycles;
	assign scl_w = !(m_scl_low | scl_oe);
	assign sda_w = !(m_sda_low | sda_oe);
	iss_top dut (.clk(clk), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'h1),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.scl_in(scl_w), .sda_in(sda_w), .sleeping(sleeping),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
		.sda_oe(sda_oe));
	iss_master_model m (.scl(scl_w), .sda(sda_w), .scl_low(m_scl_low),
		.sda_low(m_sda_low));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			mismatches++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [2:0] a,
		input logic [7:0] v);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {24'h0, v};
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		rd_v = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	// status compare under a mask; hold and ack bits vary by phase
	task automatic st(input logic [7:0] mask, input logic [7:0] exp);
		bus(1'b0, `ISS_REG_STAT, 8'h00);
		check(rd_v & {24'h0, mask}, {24'h0, exp});
	endtask
	task automatic hold(input logic exp);
		repeat (8) @(posedge clk);
		check({31'h0, scl_oe}, {31'h0, exp});
	endtask
	task automatic t_reset();
		st(8'hff, 8'h00);
		check({30'h0, scl_oe, sda_oe}, 32'h0);
		check({30'h0, scl_out, sda_out}, 32'h0);
		bus(1'b1, `ISS_REG_CTRL, 8'h48);
		bus(1'b0, `ISS_REG_CTRL, 8'h00);
		check(rd_v, 32'h08);
		bus(1'b1, `ISS_REG_OWN, 8'h54);
	endtask
	task automatic t_mismatch();
		m.start();
		m.wr8({7'h11, 1'b0});
		hold(1'b0);
		m.bit_io(1'b1, r);
		check({31'h0, r}, 32'h1);
		m.stop();
		st(8'hc4, 8'h00);
	endtask
	task automatic t_write();
		bus(1'b1, `ISS_REG_CTRL, 8'h0c);
		m.start();
		m.wr8({7'h2a, 1'b0});
		hold(1'b1);
		st(8'hc3, 8'h41);
		bus(1'b1, `ISS_REG_CMD, 8'h03);
		hold(1'b0);
		st(8'hc0, 8'h00);
		m.bit_io(1'b1, r);
		check({31'h0, r}, 32'h0);
		m.wr8(8'h5c);
		hold(1'b1);
		st(8'hc0, 8'h80);
		bus(1'b0, `ISS_REG_DATA, 8'h00);
		check(rd_v, 32'h5c);
		bus(1'b1, `ISS_REG_CMD, 8'h03);
		m.bit_io(1'b1, r);
		check({31'h0, r}, 32'h0);
		m.stop();
		hold(1'b0);
		st(8'h41, 8'h40);
		bus(1'b1, `ISS_REG_STAT, 8'hc0);
		st(8'hc0, 8'h00);
	endtask
	task automatic t_read();
		bus(1'b1, `ISS_REG_CTRL, 8'h8c);
		bus(1'b0, `ISS_REG_CTRL, 8'h00);
		check(rd_v, 32'h8c);
		m.start();
		m.wr8({7'h2a, 1'b1});
		st(8'h43, 8'h43);
		bus(1'b1, `ISS_REG_CMD, 8'h03);
		m.bit_io(1'b1, r);
		check({31'h0, r}, 32'h0);
		hold(1'b1);
		st(8'hc0, 8'h80);
		bus(1'b1, `ISS_REG_DATA, 8'ha5);
		bus(1'b1, `ISS_REG_CMD, 8'h03);
		m.rd8(d);
		check({24'h0, d}, 32'ha5);
		m.bit_io(1'b0, r);
		hold(1'b1);
		st(8'h90, 8'h80);
		bus(1'b1, `ISS_REG_DATA, 8'h80);
		bus(1'b1, `ISS_REG_CMD, 8'h03);
		// master pulls low under the slave's high bit on purpose
		m.wr8(8'h00);
		st(8'h08, 8'h08);
		check({30'h0, scl_oe, sda_oe}, 32'h0);
		m.bit_io(1'b1, r);
		hold(1'b0);
		m.rstart();
		st(8'h08, 8'h00);
		m.wr8({7'h11, 1'b1});
		m.bit_io(1'b1, r);
		check({31'h0, r}, 32'h1);
		m.stop();
		bus(1'b1, `ISS_REG_STAT, 8'hcc);
	endtask
	task automatic t_prom();
		bus(1'b1, `ISS_REG_CTRL, 8'h0a);
		m.start();
		m.wr8({7'h33, 1'b0});
		st(8'h40, 8'h40);
		bus(1'b1, `ISS_REG_CMD, 8'h07);
		m.bit_io(1'b1, r);
		check({31'h0, r}, 32'h1);
		m.stop();
		bus(1'b1, `ISS_REG_CTRL, 8'h08);
		m.start();
		m.wr8(8'h00);
		st(8'h40, 8'h40);
		bus(1'b1, `ISS_REG_CMD, 8'h03);
		m.bit_io(1'b1, r);
		check({31'h0, r}, 32'h0);
		m.stop();
	endtask
	task automatic t_sleep();
		@(posedge clk);
		sleeping <= 1'b1;
		m.start();
		hold(1'b1);
		repeat (40) @(posedge clk);
		check({31'h0, scl_oe}, 32'h1);
		repeat (60) @(posedge clk);
		check({31'h0, scl_oe}, 32'h0);
		sleeping <= 1'b0;
		m.stop();
		st(8'h04, 8'h04);
		bus(1'b1, `ISS_REG_STAT, 8'h04);
		st(8'h04, 8'h00);
	endtask
	initial begin
		rstn = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 3'h0;
		avs_writedata = 32'h0;
		sleeping = 1'b0;
		mismatches = 0;
		total_checks = 0;
		cycles = 0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		bus(1'b1, `ISS_REG_CTRL, 8'h08);
		t_mismatch();
		t_write();
		t_read();
		t_prom();
		t_sleep();
		test_done();
	end
endmodule
`default_nettype wire
